// >>> logic/rcs_pkg.sv
// Package for the regulator control and status block.
// Assumes a single 50 MHz clock and an asynchronous active-high reset.
package rcs_pkg;
    // Voltage code width; bits [5:3] pick the coarse range, [2:0] the step.
    localparam int CODE_W = 6;
    localparam int CODE_RANGE_MSB = 5;
    localparam int CODE_RANGE_LSB = 3;
    localparam int CODE_STEP_MSB = 2;
    localparam int CODE_STEP_LSB = 0;
    // Counts of step-down converters and linear regulators.
    localparam int NUM_BUCK = 4;
    localparam int NUM_LDO = 8;
    localparam int NUM_REG = NUM_BUCK + NUM_LDO;
    // First buck that has the pin-selected pair of code banks (zero-based).
    localparam int FIRST_BANKED = 1;
    // Default output code after reset: one six-bit code shared by every regulator.
    localparam logic [CODE_W-1:0] DEFAULT_CODE = 6'h1_8;
    // Reset values of the software bits.
    localparam logic ENABLE_RESET = 1'b0;
    localparam logic UNMASK_RESET = 1'b0;
    localparam logic DISCHARGE_RESET = 1'b0;
    // State of each regulator's fault latch, one-hot.
    typedef enum logic [2:0] {
        RCS_IDLE = 3'b001,
        RCS_FAULT = 3'b010,
        RCS_CLEARED = 3'b100
    } rcs_fault_t;
endpackage : rcs_pkg

// >>> logic/rcs_fault_latch.sv
// Fault latch for one regulator: holds an interrupt request once raised.
// Assumes power-good, enable and read strobes synchronous to ref_clk.
module rcs_fault_latch (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic power_good,
    input wire logic enabled,
    input wire logic unmask,
    input wire logic status_read,
    output logic request
);
    ////////////////////////////////////////////////////////////////////////
    // The latch walks IDLE -> FAULT -> IDLE, through CLEARED when the read comes before recovery.
    rcs_pkg::rcs_fault_t state;
    rcs_pkg::rcs_fault_t next_state;
    logic recovered;

    // Recovery means the regulator is off or back in regulation.
    assign recovered = !enabled || power_good;

    // Next state of the latch.
    always_comb begin
        next_state = state;
        unique case (state)
            rcs_pkg::RCS_IDLE: begin
                // Only an unmasked undervoltage of a running regulator raises a request.
                if (unmask && enabled && !power_good) begin
                    next_state = rcs_pkg::RCS_FAULT;
                end
            end
            rcs_pkg::RCS_FAULT: begin
                // Both recovery and a read are needed; either order is accepted.
                if (status_read && recovered) begin
                    next_state = rcs_pkg::RCS_IDLE;
                end else if (status_read) begin
                    next_state = rcs_pkg::RCS_CLEARED;
                end
            end
            rcs_pkg::RCS_CLEARED: begin
                // The read is remembered; wait for recovery alone.
                if (recovered) begin
                    next_state = rcs_pkg::RCS_IDLE;
                end
            end
            default: begin
                next_state = rcs_pkg::RCS_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= rcs_pkg::RCS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // The request is high in either holding state.
    assign request = (state != rcs_pkg::RCS_IDLE);
endmodule : rcs_fault_latch

// >>> logic/rcs_regulator_control_status.sv
// Control and status bits for four step-down converters and eight linear regulators.
// Assumes the host interface engine presents bits as plain synchronous ports.
// What this block does
// - Reset loads the one preset default voltage code
// - Bank-select pin picks bank zero or one
// - Host writes selected bank; device applies code
// - Six-bit code: coarse range and step
// - Linear regulator codes writable any time
// - Buck enable follows its written bit
// - Linear enable follows its written bit
// - Discharge only when disabled and bit set
// - Buck power-good mirrors its undervoltage comparator
// - Linear power-good mirrors its undervoltage comparator
// - Unmasked undervoltage of an enabled regulator drives interrupt low
// - Interrupt holds until recovered and flag read
// - Linear faults use the same unmask
// - Host reaches bits by single-byte commands
module rcs_regulator_control_status #(
    parameter int NUM_BUCK = rcs_pkg::NUM_BUCK,
    parameter int NUM_LDO = rcs_pkg::NUM_LDO
) (
    input wire logic ref_clk,
    input wire logic rst,
    // Pin that picks the code bank of the banked converters.
    input wire logic voltage_bank_select_pin,
    // Single-byte write strobe and target from the host engine.
    input wire logic code_write,
    input wire logic [3:0] code_write_index,
    input wire logic [rcs_pkg::CODE_W-1:0] code_write_value,
    // Software control bits, one per regulator; discharge bits for the linear regulators only.
    input wire logic [NUM_BUCK+NUM_LDO-1:0] enable_bits,
    input wire logic [NUM_BUCK+NUM_LDO-1:0] fault_irq_unmask,
    input wire logic [NUM_LDO-1:0] output_discharge_enable,
    // Undervoltage comparator outputs, high when the output is low.
    input wire logic [NUM_BUCK+NUM_LDO-1:0] undervoltage,
    // Pulse for each regulator whose power-good flag the host reads.
    input wire logic [NUM_BUCK+NUM_LDO-1:0] power_good_read,
    // Active voltage code of every regulator, packed six bits each.
    output logic [(NUM_BUCK+NUM_LDO)*rcs_pkg::CODE_W-1:0] voltage_code,
    output logic [NUM_BUCK+NUM_LDO-1:0] regulator_on,
    output logic [NUM_LDO-1:0] discharge_on,
    output logic [NUM_BUCK+NUM_LDO-1:0] power_good,
    output logic interrupt_request_low
);
    localparam int NR = NUM_BUCK + NUM_LDO;
    localparam int CW = rcs_pkg::CODE_W;

    ////////////////////////////////////////////////////////////////////////
    // Code storage. Index 0..NR-1 is bank zero (and the only bank of the
    // unbanked regulators); code_bank_one index 1..NUM_BUCK-1 is bank one of the banked bucks.
    // A write to a banked buck lands in the bank the pin selects now, so
    // the host always changes the code the converter is using.
    logic [CW-1:0] code_bank_zero [NR];
    logic [CW-1:0] code_bank_one [NUM_BUCK];
    logic [CW-1:0] next_code_bank_zero [NR];
    logic [CW-1:0] next_code_bank_one [NUM_BUCK];
    logic [NR-1:0] latch_request;

    // Next values of the code banks.
    always_comb begin
        for (int i = 0; i < NR; i++) begin
            next_code_bank_zero[i] = code_bank_zero[i];
            // A write to this regulator takes bank zero unless banked with the pin high.
            if (code_write && (int'(code_write_index) == i)) begin
                if (!(i >= rcs_pkg::FIRST_BANKED && i < NUM_BUCK && voltage_bank_select_pin)) begin
                    next_code_bank_zero[i] = code_write_value;
                end
            end
        end
        for (int i = 0; i < NUM_BUCK; i++) begin
            next_code_bank_one[i] = code_bank_one[i];
            if (code_write && (int'(code_write_index) == i) && i >= rcs_pkg::FIRST_BANKED
                && voltage_bank_select_pin) begin
                next_code_bank_one[i] = code_write_value;
            end
        end
    end

    // Code bank registers; all start at the preset default.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NR; i++) begin
                code_bank_zero[i] <= rcs_pkg::DEFAULT_CODE;
            end
            for (int i = 0; i < NUM_BUCK; i++) begin
                code_bank_one[i] <= rcs_pkg::DEFAULT_CODE;
            end
        end else begin
            code_bank_zero <= next_code_bank_zero;
            code_bank_one <= next_code_bank_one;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output stage: every output is registered, one cycle behind its inputs; a written code and the interrupt trail the write or fault by two.
    logic [NR*CW-1:0] next_voltage_code;
    logic [NR-1:0] next_regulator_on;
    logic [NUM_LDO-1:0] next_discharge_on;
    logic [NR-1:0] next_power_good;
    logic next_interrupt_request_low;

    // Active code selection, enables, discharge, power-good and interrupt.
    always_comb begin
        for (int i = 0; i < NR; i++) begin
            if (i >= rcs_pkg::FIRST_BANKED && i < NUM_BUCK && voltage_bank_select_pin) begin
                next_voltage_code[i*CW +: CW] = code_bank_one[i];
            end else begin
                next_voltage_code[i*CW +: CW] = code_bank_zero[i];
            end
        end
        next_regulator_on = enable_bits;
        // Discharging a running regulator would fight its own output.
        next_discharge_on = output_discharge_enable & ~enable_bits[NR-1:NUM_BUCK];
        next_power_good = ~undervoltage;
        next_interrupt_request_low = ~(|latch_request);
    end

    // Output registers.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            voltage_code <= {NR{rcs_pkg::DEFAULT_CODE}};
            regulator_on <= {NR{rcs_pkg::ENABLE_RESET}};
            discharge_on <= '0;
            power_good <= '0;
            interrupt_request_low <= 1'b1;
        end else begin
            voltage_code <= next_voltage_code;
            regulator_on <= next_regulator_on;
            discharge_on <= next_discharge_on;
            power_good <= next_power_good;
            interrupt_request_low <= next_interrupt_request_low;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One fault latch per regulator, bucks and linear regulators alike.
    for (genvar g = 0; g < NR; g++) begin : g_latch
        rcs_fault_latch u_latch (
            .ref_clk(ref_clk),
            .rst(rst),
            .power_good(!undervoltage[g]),
            .enabled(enable_bits[g]),
            .unmask(fault_irq_unmask[g]),
            .status_read(power_good_read[g]),
            .request(latch_request[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Check helper: remembers, per regulator, a latched fault whose flag the
    // host has not yet read. No output depends on it, so synthesis may trim
    // it; it exists so that the hold check below can tell a legal release
    // (read seen earlier, recovery now) from a release that skipped the read.
    logic [NR-1:0] chk_prev_request; // Latch requests one cycle earlier.
    logic [NR-1:0] chk_read_owed; // Fault raised and flag not yet read.
    logic [NR-1:0] next_chk_prev_request;
    logic [NR-1:0] next_chk_read_owed;

    // A rising request owes a read; a read pulse settles the debt.
    always_comb begin
        next_chk_prev_request = latch_request;
        next_chk_read_owed = (chk_read_owed | (latch_request & ~chk_prev_request)) & ~power_good_read;
    end

    // Helper registers, cleared with the rest of the block.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            chk_prev_request <= '0;
            chk_read_owed <= '0;
        end else begin
            chk_prev_request <= next_chk_prev_request;
            chk_read_owed <= next_chk_read_owed;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks. Outputs are registered, so most checks look one edge later.
    property p_reset_outputs;
        @(posedge ref_clk) $fell(rst) |-> regulator_on == '0 && discharge_on == '0 && interrupt_request_low;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not idle after reset");

    // Bank zero drives each banked converter while the pin is low.
    for (genvar g = rcs_pkg::FIRST_BANKED; g < NUM_BUCK; g++) begin : g_bank_check
        property p_bank_zero;
            @(posedge ref_clk) disable iff (rst)
            !voltage_bank_select_pin |=> voltage_code[g*CW +: CW] == $past(code_bank_zero[g]);
        endproperty
        a_bank_zero: assert property (p_bank_zero) else $error("bank zero not applied");
    end

    // A linear regulator code written by the host shows two edges later,
    // unless a second write to the same regulator overtakes it.
    for (genvar g = NUM_BUCK; g < NR; g++) begin : g_ldo_check
        sequence s_ldo_write;
            code_write && int'(code_write_index) == g;
        endsequence
        property p_ldo_code;
            @(posedge ref_clk) disable iff (rst)
            s_ldo_write ##1 !(code_write && int'(code_write_index) == g)
            |=> voltage_code[g*CW +: CW] == $past(code_write_value, 2);
        endproperty
        a_ldo_code: assert property (p_ldo_code) else $error("linear code write not applied");
    end

    // A write to a regulator that does not exist must leave every code alone.
    sequence s_stray_write;
        code_write && int'(code_write_index) >= NR;
    endsequence
    property p_stray_write;
        @(posedge ref_clk) disable iff (rst)
        s_stray_write ##1 (!code_write && $stable(voltage_bank_select_pin)) |=> $stable(voltage_code);
    endproperty
    a_stray_write: assert property (p_stray_write) else $error("stray write changed a code");

    property p_ldo_enable;
        @(posedge ref_clk) disable iff (rst)
        1'b1 |=> regulator_on[NR-1:NUM_BUCK] == $past(enable_bits[NR-1:NUM_BUCK]);
    endproperty
    a_ldo_enable: assert property (p_ldo_enable) else $error("linear enable not followed");

    property p_ldo_pgood;
        @(posedge ref_clk) disable iff (rst)
        1'b1 |=> power_good[NR-1:NUM_BUCK] == ~$past(undervoltage[NR-1:NUM_BUCK]);
    endproperty
    a_ldo_pgood: assert property (p_ldo_pgood) else $error("linear power-good mismatch");

    property p_irq_ldo;
        @(posedge ref_clk) disable iff (rst)
        |(fault_irq_unmask[NR-1:NUM_BUCK] & enable_bits[NR-1:NUM_BUCK] & undervoltage[NR-1:NUM_BUCK])
        |-> ##2 !interrupt_request_low;
    endproperty
    a_irq_ldo: assert property (p_irq_ldo) else $error("linear fault not raised");

    // With nothing latched and nothing unmasked failing, the line stays high.
    property p_irq_quiet;
        @(posedge ref_clk) disable iff (rst)
        (latch_request == '0 && (fault_irq_unmask & enable_bits & undervoltage) == '0)
        |-> ##2 interrupt_request_low;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without unmasked fault");

    property p_reset_code;
        @(posedge ref_clk) $fell(rst) |-> voltage_code == {NR{rcs_pkg::DEFAULT_CODE}};
    endproperty
    a_reset_code: assert property (p_reset_code) else $error("code not default after reset");

    property p_bank_one;
        @(posedge ref_clk) disable iff (rst)
        voltage_bank_select_pin |=> voltage_code[NR*0+CW*1 +: CW] == $past(code_bank_one[1]);
    endproperty
    a_bank_one: assert property (p_bank_one) else $error("bank one not applied");

    sequence s_write_buck2;
        code_write && code_write_index == 4'h1 && !voltage_bank_select_pin;
    endsequence
    property p_write_applied;
        @(posedge ref_clk) disable iff (rst)
        s_write_buck2 ##1 (!voltage_bank_select_pin && !(code_write && code_write_index == 4'h1))
        |=> voltage_code[CW +: CW] == $past(code_write_value, 2);
    endproperty
    a_write_applied: assert property (p_write_applied) else $error("written code not applied");

    property p_enable;
        @(posedge ref_clk) disable iff (rst) 1'b1 |=> regulator_on == $past(enable_bits);
    endproperty
    a_enable: assert property (p_enable) else $error("enable not followed");

    property p_discharge;
        @(posedge ref_clk) disable iff (rst)
        1'b1 |=> discharge_on == $past(output_discharge_enable & ~enable_bits[NR-1:NUM_BUCK]);
    endproperty
    a_discharge: assert property (p_discharge) else $error("discharge without enable bit");

    property p_pgood;
        @(posedge ref_clk) disable iff (rst) 1'b1 |=> power_good == ~$past(undervoltage);
    endproperty
    a_pgood: assert property (p_pgood) else $error("power-good mismatch");

    property p_irq_set;
        @(posedge ref_clk) disable iff (rst)
        |(fault_irq_unmask & enable_bits & undervoltage) |-> ##2 !interrupt_request_low;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("interrupt not raised");

    property p_irq_hold;
        @(posedge ref_clk) disable iff (rst)
        |chk_read_owed |=> !interrupt_request_low;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without read");

    property p_irq_or;
        @(posedge ref_clk) disable iff (rst) 1'b1 |=> interrupt_request_low == ~$past(|latch_request);
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("interrupt not OR of requests");
endmodule : rcs_regulator_control_status

// >>> sim/rcs_host_model.sv
// Host model: stands in for the processor that reaches the control bits.
// Assumes the bench calls its tasks; every strobe changes at a falling edge.
module rcs_host_model (
    input wire logic ref_clk,
    output logic code_write,
    output logic [3:0] code_write_index,
    output logic [5:0] code_write_value,
    output logic [11:0] power_good_read
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////
    // Idle values at time zero, so the block never samples an unknown strobe.
    initial begin
        code_write = 1'b0;
        code_write_index = 4'h0;
        code_write_value = 6'h0_0;
        power_good_read = 12'h000;
    end
    // Single-byte code write: one strobe cycle, then the data lines show a changed value.
    task automatic write_code(input logic [3:0] idx, input logic [5:0] val);
        @(negedge ref_clk);
        code_write = 1'b1;
        code_write_index = idx;
        code_write_value = val;
        @(negedge ref_clk);
        code_write = 1'b0;
        // Released lines are inverted so a stale value cannot pass as held data.
        code_write_value = ~val;
    endtask : write_code
    // Single-byte status read: a one-cycle pulse for the flag being read.
    task automatic read_flag(input int idx);
        @(negedge ref_clk);
        power_good_read = 12'h001 << idx;
        @(negedge ref_clk);
        power_good_read = 12'h000;
    endtask : read_flag
endmodule : rcs_host_model

// >>> sim/tb_regulator_control_status.sv
// Self-checking bench for the regulator control and status block.
// Assumes the host model file is compiled first; inputs change at falling edges.
module tb_regulator_control_status;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst, pin, cw;
    logic [3:0] cwi;
    logic [5:0] cwv;
    logic [11:0] en, unm, uv, pgr, ron, pg;
    logic [7:0] dis, don;
    logic [71:0] vc;
    logic irq;
    logic [5:0] b0[12], b1[12]; // Expected bank contents per regulator.
    int failures = 0;
    int samples_checked = 0;
    ////////////////////////////////////////////////////////////////////////
    // Clock at 50 MHz.
    initial ref_clk = 1'b0;
    always #10 ref_clk = ~ref_clk;
    rcs_host_model i_host (.ref_clk(ref_clk), .code_write(cw), .code_write_index(cwi),
        .code_write_value(cwv), .power_good_read(pgr));
    rcs_regulator_control_status i_dut (.ref_clk(ref_clk), .rst(rst), .voltage_bank_select_pin(pin),
        .code_write(cw), .code_write_index(cwi), .code_write_value(cwv), .enable_bits(en),
        .fault_irq_unmask(unm), .output_discharge_enable(dis), .undervoltage(uv),
        .power_good_read(pgr), .voltage_code(vc), .regulator_on(ron), .discharge_on(don),
        .power_good(pg), .interrupt_request_low(irq));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [71:0] seen, input logic [71:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc
    // Expected active codes: banked bucks follow the pin level.
    function automatic logic [71:0] exp_codes();
        logic [71:0] r;
        r = 72'h0;
        for (int i = 0; i < 12; i++) begin
            r[6*i +: 6] = (pin && i >= rcs_pkg::FIRST_BANKED && i < rcs_pkg::NUM_BUCK) ? b1[i] : b0[i];
        end
        return r;
    endfunction : exp_codes
    // Write through the host and track which bank the write lands in.
    task automatic wr(input logic [3:0] idx, input logic [5:0] val);
        i_host.write_code(idx, val);
        if (idx < 4'hc) begin
            if (pin && idx >= 4'h1 && idx < 4'h4) b1[idx] = val;
            else b0[idx] = val;
        end
    endtask : wr
    task automatic apply_en(input logic [11:0] e, input logic [7:0] d);
        en = e;
        dis = d;
        cyc(1);
        check({60'h0, ron}, {60'h0, e});
        check({64'h0, don}, {64'h0, ~e[11:4] & d});
    endtask : apply_en
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    // Watchdog: the tests need well under two thousand cycles.
    initial begin
        #200us;
        failures++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1; pin = 1'b0; en = 12'h000; unm = 12'h000; uv = 12'h000; dis = 8'h00;
        for (int i = 0; i < 12; i++) begin
            b0[i] = rcs_pkg::DEFAULT_CODE;
            b1[i] = rcs_pkg::DEFAULT_CODE;
        end
        cyc(20);
        rst = 1'b0;
        cyc(1);
        check(vc, exp_codes());
        check({71'h0, irq}, 72'h1);
        $display("test reset done");
        // Bank selection, with writes landing in the selected bank only.
        wr(4'h1, 6'h2_a);
        wr(4'h0, 6'h3_f);
        cyc(2);
        check(vc, exp_codes());
        pin = 1'b1;
        cyc(2);
        check(vc, exp_codes());
        wr(4'h1, 6'h1_5);
        wr(4'h2, 6'h0_0);
        wr(4'h3, 6'h3_f);
        cyc(2);
        check(vc, exp_codes());
        pin = 1'b0;
        cyc(2);
        check(vc, exp_codes());
        $display("test banks done");
        // Linear codes at both ends of the code range; indexes past the last are ignored.
        for (int i = 4; i < 12; i++) wr(4'(i), (i == 4) ? 6'h0_0 : 6'(i * 9));
        wr(4'hc, 6'h0_1);
        wr(4'hf, 6'h0_2);
        cyc(2);
        check(vc, exp_codes());
        $display("test codes done");
        apply_en(12'ha5c, 8'hf0);
        apply_en(12'h5a3, 8'h3c);
        uv = 12'h813;
        cyc(1);
        check({60'h0, pg}, {60'h0, ~uv});
        $display("test enables done");
        // Masked fault leaves the interrupt high; unmasked fault pulls it low.
        en = 12'hfff; uv = 12'h004;
        cyc(3);
        check({71'h0, irq}, 72'h1);
        unm = 12'h004;
        cyc(2);
        check({71'h0, irq}, 72'h0);
        uv = 12'h000;
        cyc(4);
        check({71'h0, irq}, 72'h0);
        i_host.read_flag(2);
        cyc(2);
        check({71'h0, irq}, 72'h1);
        // Linear fault read before recovery; a buck fault raised after the read holds the line once the linear one recovers.
        unm = 12'h084; uv = 12'h080;
        cyc(2);
        check({71'h0, irq}, 72'h0);
        i_host.read_flag(7);
        cyc(3);
        check({71'h0, irq}, 72'h0);
        uv = 12'h084;
        cyc(2);
        uv = 12'h000; en = 12'hf7f;
        cyc(3);
        check({71'h0, irq}, 72'h0);
        i_host.read_flag(2);
        cyc(2);
        check({71'h0, irq}, 72'h1);
        unm = 12'h000; en = 12'hfff; uv = 12'h100;
        cyc(3);
        check({71'h0, irq}, 72'h1);
        $display("test interrupt done");
        final_report();
    end
endmodule : tb_regulator_control_status
